// ### logic/suc_clk_gen.sv
`timescale 1ns/1ps
module suc_clk_gen #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Configuration
  input wire logic [DIV_W-1:0] baud_div_i,
  input wire logic ext_clk_i,
  input wire logic sync_mode_i,
  // Serial clock pin
  input wire logic sck_i,
  // Timing
  output logic tick16_o,
  output logic bit_rise_o,
  output logic bit_fall_o,
  output logic bit_clk_o
);
  logic [DIV_W-1:0] div_q;
  logic [3:0] phase_q;
  logic [2:0] sck_q;
  logic int_tick;
  logic ext_rise;
  logic ext_fall;

  assign int_tick = ce_i && (div_q >= baud_div_i);
  // Edges look at stages two and three only
  assign ext_rise = ce_i && sck_q[1] && !sck_q[2];
  assign ext_fall = ce_i && !sck_q[1] && sck_q[2];

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_q <= '0;
    end else if (ce_i) begin
      div_q <= (div_q >= baud_div_i) ? '0 : div_q + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_q <= 4'h0;
    end else if (int_tick) begin
      phase_q <= phase_q + 4'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // Idle level of the pulled-up pin, so no false edge follows reset
      sck_q <= 3'h7;
    end else if (ce_i) begin
      sck_q <= {sck_q[1:0], sck_i};
    end
  end

  // Internal bit clock is sixteen ticks long, high in its second half
  assign tick16_o = (ext_clk_i && !sync_mode_i) ? ext_rise : int_tick;
  assign bit_rise_o = (ext_clk_i && sync_mode_i) ? ext_rise :
                      (int_tick && phase_q == suc_pkg::PHASE_RISE);
  assign bit_fall_o = (ext_clk_i && sync_mode_i) ? ext_fall :
                      (int_tick && phase_q == suc_pkg::PHASE_FALL);
  assign bit_clk_o = phase_q[3];
endmodule // suc_clk_gen

// ### logic/suc_pkg.sv
// What this block does
// - Normal bit meanings only outside card mode
// - Bit 7 gates transmit-empty request
// - Bit 6 gates receive-full and error requests
// - Transmit only while bit 5 set
// - Receive only while bit 4 set
// - Address wait only async with multiprocessor format
// - Address wait drops frames with mp bit 0
// - Mp bit 1 clears address wait, resumes reception
// - Bit 2 gates transmit-end request
// - Async 00: internal clock, pin released
// - Async 01: internal clock, bit clock out
// - Async 1X: external sixteen-times clock in
// - Sync 0X: internal clock driven out
// - Sync 1X: pin is external clock input
package suc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_EVT = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_BAUD = 8'h14;
  localparam logic [7:0] OFS_TXD = 8'h18;
  localparam logic [7:0] OFS_RXD = 8'h1C;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  // Clock source field codes
  localparam logic [1:0] CKE_PORT = 2'h0;
  localparam logic [1:0] CKE_OUT = 2'h1;
  // Bit timing
  localparam int TICKS_PER_BIT = 16;
  localparam logic [3:0] SUB_LAST = 4'(TICKS_PER_BIT - 1);
  localparam logic [3:0] SUB_MID = 4'(TICKS_PER_BIT / 2 - 1);
  localparam logic [3:0] PHASE_RISE = SUB_MID;
  localparam logic [3:0] PHASE_FALL = SUB_LAST;
  // Frame lengths in bits; async receive counts leave out start and stop
  localparam logic [3:0] RX_LAST_PLAIN = 4'h8;
  localparam logic [3:0] RX_LAST_MP = 4'h9;
  localparam logic [3:0] TX_N_SYNC = 4'h8;
  localparam logic [3:0] TX_N_ASYNC = 4'hA;
  localparam logic [3:0] TX_N_MP = 4'hB;
  // Event bits of the event and mask registers
  localparam int EVT_TXE = 0;
  localparam int EVT_RXF = 1;
  localparam int EVT_RXE = 2;
  localparam int EVT_TXEND = 3;
  localparam int EVT_N = 4;

  typedef struct packed {
    logic tx_irq_enable;
    logic rx_irq_enable;
    logic tx_enable;
    logic rx_enable;
    logic addr_wait_enable;
    logic tx_end_irq_enable;
    logic clock_source_sel_hi;
    logic clock_source_sel_lo;
  } suc_ctrl_t;

  typedef struct packed {
    logic [3:0] rsvd;
    logic tx_mp_bit;
    logic card_mode_select;
    logic multiproc_format;
    logic sync_mode;
  } suc_mode_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } suc_wb_req_t;

  typedef struct packed {
    logic [31:0] dat;
    logic ack;
  } suc_wb_rsp_t;
endpackage

// ### logic/suc_serial_unit.sv
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module suc_serial_unit (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Register bus
  input wire suc_pkg::suc_wb_req_t wb_i,
  output suc_pkg::suc_wb_rsp_t wb_o,
  // Serial pins
  input wire logic rxd_i,
  output logic txd_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  // Interrupts
  output logic tx_empty_irq_o,
  output logic rx_full_irq_o,
  output logic rx_error_irq_o,
  output logic tx_end_irq_o,
  output logic irq_o
);
  typedef enum logic {SUC_TX_IDLE, SUC_TX_SHIFT} suc_tx_state_t;
  typedef enum logic [1:0] {SUC_RX_IDLE, SUC_RX_START, SUC_RX_BITS} suc_rx_state_t;

  suc_pkg::suc_ctrl_t ctrl_q;
  suc_pkg::suc_mode_t mode_q;
  logic [15:0] baud_q;
  logic [3:0] mask_q;
  logic [3:0] evt_q;
  logic [3:0] evt_set;
  logic [3:0] evt_gate;
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rdata_d;
  logic [7:0] adr_w;
  logic acc;
  logic wr;
  logic rd;
  logic normal;
  logic sync;
  logic tx_go;
  logic rx_go;
  logic addr_wait;
  logic tick16;
  logic bit_rise;
  logic bit_fall;
  logic bit_clk;
  logic [1:0] rxd_q;
  logic rxd;
  logic sck_oe_q;
  // Transmit side
  suc_tx_state_t tx_state_q;
  logic [7:0] tdr_q;
  logic tx_empty_flag_q;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_cnt_q;
  logic [3:0] tx_sub_q;
  logic txd_q;
  logic tx_load;
  logic tx_step;
  logic tx_done;
  // Receive side
  suc_rx_state_t rx_state_q;
  logic [8:0] rx_sh_q;
  logic [3:0] rx_cnt_q;
  logic [3:0] rx_sub_q;
  logic [3:0] rx_last;
  logic rx_step;
  logic rx_fin;
  logic rx_skip;
  logic rx_store;
  logic rx_stop;
  logic [7:0] rdr_q;
  logic rx_mp_q;
  logic rx_full_flag_q;
  logic framing_error_flag_q;
  logic overrun_error_flag_q;
  logic ctrl_wr;

  // Bus slave: one-cycle registered answer, unmapped reads give zero
  assign adr_w = {wb_i.adr[7:2], 2'b00};
  assign acc = wb_i.cyc && wb_i.stb && !ack_q && ce_i;
  assign wr = acc && wb_i.we;
  assign rd = acc && !wb_i.we;
  assign ctrl_wr = wr && wb_i.sel[0] && adr_w == suc_pkg::OFS_CTRL;
  assign wb_o = '{dat: dat_q, ack: ack_q};

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (adr_w)
      suc_pkg::OFS_CTRL: rdata_d[7:0] = ctrl_q;
      suc_pkg::OFS_MODE: rdata_d[7:0] = mode_q;
      suc_pkg::OFS_FLAGS: rdata_d[5:0] = {rx_mp_q, tx_state_q == SUC_TX_SHIFT,
                                          overrun_error_flag_q, framing_error_flag_q,
                                          rx_full_flag_q, tx_empty_flag_q};
      suc_pkg::OFS_EVT: rdata_d[3:0] = evt_q;
      suc_pkg::OFS_MASK: rdata_d[3:0] = mask_q;
      suc_pkg::OFS_BAUD: rdata_d[15:0] = baud_q;
      suc_pkg::OFS_TXD: rdata_d[7:0] = tdr_q;
      suc_pkg::OFS_RXD: rdata_d[7:0] = rdr_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_q <= acc;
      if (rd) begin
        dat_q <= rdata_d;
      end
    end
  end

  // Control register; a bus write beats the hardware release of address wait
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q <= suc_pkg::CTRL_RST;
    end else if (ce_i) begin
      if (ctrl_wr) begin
        ctrl_q <= wb_i.dat[7:0];
      end else if (rx_fin && addr_wait && rx_sh_q[8]) begin
        ctrl_q.addr_wait_enable <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_q <= suc_pkg::MODE_RST;
      mask_q <= suc_pkg::MASK_RST;
      baud_q <= suc_pkg::BAUD_RST;
    end else if (wr) begin
      if (adr_w == suc_pkg::OFS_MODE && wb_i.sel[0]) begin
        mode_q <= {4'h0, wb_i.dat[3:0]};
      end
      if (adr_w == suc_pkg::OFS_MASK && wb_i.sel[0]) begin
        mask_q <= wb_i.dat[3:0];
      end
      if (adr_w == suc_pkg::OFS_BAUD && wb_i.sel[0]) begin
        baud_q[7:0] <= wb_i.dat[7:0];
      end
      if (adr_w == suc_pkg::OFS_BAUD && wb_i.sel[1]) begin
        baud_q[15:8] <= wb_i.dat[15:8];
      end
    end
  end

  // Card mode leaves every normal function of the control bits dormant
  assign normal = !mode_q.card_mode_select;
  assign sync = mode_q.sync_mode;
  assign tx_go = normal && ctrl_q.tx_enable;
  assign rx_go = normal && ctrl_q.rx_enable;
  assign addr_wait = normal && !sync && mode_q.multiproc_format
                     && ctrl_q.addr_wait_enable;

  suc_clk_gen #(
    .DIV_W(16)
  ) u_clk_gen (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .baud_div_i(baud_q),
    .ext_clk_i(ctrl_q.clock_source_sel_hi),
    .sync_mode_i(sync),
    .sck_i(sck_i),
    .tick16_o(tick16),
    .bit_rise_o(bit_rise),
    .bit_fall_o(bit_fall),
    .bit_clk_o(bit_clk)
  );

  // Pin drive: async 00 and any 1X release the pin
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sck_oe_q <= 1'b0;
    end else if (ce_i) begin
      sck_oe_q <= normal && (sync ? !ctrl_q.clock_source_sel_hi
                  : {ctrl_q.clock_source_sel_hi, ctrl_q.clock_source_sel_lo}
                    == suc_pkg::CKE_OUT);
    end
  end
  assign sck_oe_o = sck_oe_q;
  assign sck_o = bit_clk;

  // Receive pin crosses in from outside
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rxd_q <= 2'b11;
    end else if (ce_i) begin
      rxd_q <= {rxd_q[0], rxd_i};
    end
  end
  assign rxd = rxd_q[1];

  // Transmitter; sync frames start on a falling edge so bit 0 meets a whole rise
  assign tx_load = tx_go && tx_state_q == SUC_TX_IDLE && !tx_empty_flag_q
                   && (!sync || bit_fall);
  assign tx_step = tx_state_q == SUC_TX_SHIFT
                   && (sync ? bit_fall : (tick16 && tx_sub_q == suc_pkg::SUB_LAST));
  assign tx_done = tx_go && tx_step && tx_cnt_q == 4'h1;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tdr_q <= 8'h00;
      tx_empty_flag_q <= 1'b1;
    end else if (ce_i) begin
      if (!tx_go) begin
        tx_empty_flag_q <= 1'b1;
      end else if (wr && wb_i.sel[0] && adr_w == suc_pkg::OFS_TXD) begin
        tdr_q <= wb_i.dat[7:0];
        tx_empty_flag_q <= 1'b0;
      end else if (tx_load) begin
        tx_empty_flag_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_state_q <= SUC_TX_IDLE;
      tx_sh_q <= 11'h7FF;
      tx_cnt_q <= 4'h0;
      tx_sub_q <= 4'h0;
      txd_q <= 1'b1;
    end else if (ce_i) begin
      case (tx_state_q)
        SUC_TX_IDLE: begin
          txd_q <= 1'b1;
          if (tx_load) begin
            tx_state_q <= SUC_TX_SHIFT;
            tx_sub_q <= 4'h0;
            if (sync) begin
              tx_sh_q <= {3'b111, tdr_q};
              tx_cnt_q <= suc_pkg::TX_N_SYNC;
              txd_q <= tdr_q[0];
            end else begin
              tx_sh_q <= {1'b1, mode_q.tx_mp_bit || !mode_q.multiproc_format, tdr_q, 1'b0};
              tx_cnt_q <= mode_q.multiproc_format ? suc_pkg::TX_N_MP : suc_pkg::TX_N_ASYNC;
              txd_q <= 1'b0;
            end
          end
        end
        SUC_TX_SHIFT: begin
          if (!tx_go) begin
            tx_state_q <= SUC_TX_IDLE;
            txd_q <= 1'b1;
          end else begin
            if (tick16) begin
              tx_sub_q <= tx_sub_q + 4'h1;
            end
            if (tx_done) begin
              tx_state_q <= SUC_TX_IDLE;
              txd_q <= 1'b1;
            end else if (tx_step) begin
              tx_sh_q <= {1'b1, tx_sh_q[10:1]};
              tx_cnt_q <= tx_cnt_q - 4'h1;
              txd_q <= tx_sh_q[1];
            end
          end
        end
        default: tx_state_q <= SUC_TX_IDLE;
      endcase
    end
  end
  assign txd_o = txd_q;

  // Receiver; async samples mid-bit, sync samples on rising edges
  assign rx_last = (!sync && mode_q.multiproc_format) ? suc_pkg::RX_LAST_MP
                   : suc_pkg::RX_LAST_PLAIN;
  assign rx_step = sync ? bit_rise : (tick16 && rx_sub_q == suc_pkg::SUB_LAST);
  assign rx_fin = ce_i && rx_go && rx_state_q == SUC_RX_BITS
                  && (sync ? rx_cnt_q == rx_last : (rx_step && rx_cnt_q == rx_last));
  assign rx_stop = sync || rxd;
  assign rx_skip = addr_wait && !rx_sh_q[8];
  assign rx_store = rx_fin && !rx_skip && !rx_full_flag_q;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_state_q <= SUC_RX_IDLE;
      rx_sh_q <= 9'h000;
      rx_cnt_q <= 4'h0;
      rx_sub_q <= 4'h0;
    end else if (ce_i) begin
      if (!rx_go) begin
        rx_state_q <= SUC_RX_IDLE;
      end else begin
        case (rx_state_q)
          SUC_RX_IDLE: begin
            rx_sub_q <= 4'h0;
            rx_cnt_q <= 4'h0;
            rx_sh_q <= 9'h000;
            if (sync) begin
              rx_state_q <= SUC_RX_BITS;
            end else if (!rxd) begin
              rx_state_q <= SUC_RX_START;
            end
          end
          SUC_RX_START: begin
            if (tick16) begin
              rx_sub_q <= rx_sub_q + 4'h1;
              if (rx_sub_q == suc_pkg::SUB_MID) begin
                rx_sub_q <= 4'h0;
                rx_state_q <= rxd ? SUC_RX_IDLE : SUC_RX_BITS;
              end
            end
          end
          SUC_RX_BITS: begin
            if (tick16) begin
              rx_sub_q <= rx_sub_q + 4'h1;
            end
            if (rx_fin) begin
              rx_state_q <= SUC_RX_IDLE;
            end else if (rx_step && rx_cnt_q != rx_last) begin
              rx_sh_q[rx_cnt_q] <= rxd;
              rx_cnt_q <= rx_cnt_q + 4'h1;
            end
          end
          default: rx_state_q <= SUC_RX_IDLE;
        endcase
      end
    end
  end

  // Receive flags; a new frame wins over a software clear in the same cycle
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdr_q <= 8'h00;
      rx_mp_q <= 1'b0;
      rx_full_flag_q <= 1'b0;
      framing_error_flag_q <= 1'b0;
      overrun_error_flag_q <= 1'b0;
    end else if (ce_i) begin
      if (rx_store) begin
        rdr_q <= rx_sh_q[7:0];
        rx_mp_q <= rx_sh_q[8];
        rx_full_flag_q <= 1'b1;
      end else if (rd && adr_w == suc_pkg::OFS_RXD) begin
        rx_full_flag_q <= 1'b0;
      end
      if (rx_fin && !rx_skip && !rx_stop) begin
        framing_error_flag_q <= 1'b1;
      end else if (wr && wb_i.sel[0] && adr_w == suc_pkg::OFS_FLAGS && wb_i.dat[2]) begin
        framing_error_flag_q <= 1'b0;
      end
      if (rx_fin && !rx_skip && rx_full_flag_q) begin
        overrun_error_flag_q <= 1'b1;
      end else if (wr && wb_i.sel[0] && adr_w == suc_pkg::OFS_FLAGS && wb_i.dat[3]) begin
        overrun_error_flag_q <= 1'b0;
      end
    end
  end

  // Sticky events, cleared by reading them; setting wins
  assign evt_set[suc_pkg::EVT_TXE] = ce_i && tx_load;
  assign evt_set[suc_pkg::EVT_RXF] = rx_store;
  assign evt_set[suc_pkg::EVT_RXE] = rx_fin && !rx_skip && (!rx_stop || rx_full_flag_q);
  assign evt_set[suc_pkg::EVT_TXEND] = ce_i && tx_done && tx_empty_flag_q;
  assign evt_gate[suc_pkg::EVT_TXE] = normal && ctrl_q.tx_irq_enable;
  assign evt_gate[suc_pkg::EVT_RXF] = normal && ctrl_q.rx_irq_enable;
  assign evt_gate[suc_pkg::EVT_RXE] = normal && ctrl_q.rx_irq_enable;
  assign evt_gate[suc_pkg::EVT_TXEND] = normal && ctrl_q.tx_end_irq_enable;

  for (genvar i = 0; i < suc_pkg::EVT_N; i++) begin : g_evt
    always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        evt_q[i] <= 1'b0;
      end else if (evt_set[i]) begin
        evt_q[i] <= 1'b1;
      end else if (rd && adr_w == suc_pkg::OFS_EVT) begin
        evt_q[i] <= 1'b0;
      end
    end
  end

  assign tx_empty_irq_o = evt_q[suc_pkg::EVT_TXE] && evt_gate[suc_pkg::EVT_TXE];
  assign rx_full_irq_o = evt_q[suc_pkg::EVT_RXF] && evt_gate[suc_pkg::EVT_RXF];
  assign rx_error_irq_o = evt_q[suc_pkg::EVT_RXE] && evt_gate[suc_pkg::EVT_RXE];
  assign tx_end_irq_o = evt_q[suc_pkg::EVT_TXEND] && evt_gate[suc_pkg::EVT_TXEND];
  assign irq_o = |(evt_q & evt_gate & mask_q);

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  a_reset_ctrl: assert property (disable iff (1'b0) $rose(nrst_i) |-> ctrl_q == 8'h00)
    else $error("control register not clear after reset");
  a_card_dormant: assert property (mode_q.card_mode_select |-> !irq_o ##1 !sck_oe_o)
    else $error("card mode still drives normal functions");
  a_tie_gate: assert property (!ctrl_q.tx_irq_enable |-> !tx_empty_irq_o)
    else $error("transmit empty request not masked");
  a_rie_gate: assert property (!ctrl_q.rx_irq_enable |-> !rx_full_irq_o && !rx_error_irq_o)
    else $error("receive requests not masked");
  a_tx_end_irq_enable_gate: assert property (!ctrl_q.tx_end_irq_enable |-> !tx_end_irq_o)
    else $error("transmit end request not masked");
  a_tx_off_idle: assert property (ce_i && !tx_go |=> txd_o && tx_state_q == SUC_TX_IDLE)
    else $error("transmit active while disabled");
  a_rx_off_idle: assert property (ce_i && !rx_go |=> rx_state_q == SUC_RX_IDLE ##1 !$rose(rx_full_flag_q))
    else $error("receive active while disabled");
  a_skip_flags: assert property (rx_fin && rx_skip |=> !$rose(rx_full_flag_q)
                                 && !$rose(framing_error_flag_q) && !$rose(overrun_error_flag_q))
    else $error("skipped frame set a flag");
  a_wait_release: assert property (rx_fin && addr_wait && rx_sh_q[8] && !ctrl_wr
                                   |=> !ctrl_q.addr_wait_enable)
    else $error("address wait not released");
  a_wait_noeffect: assert property (rx_fin && !addr_wait && !rx_full_flag_q |=> rx_full_flag_q)
    else $error("frame lost outside address wait");
  a_pin_release: assert property (ce_i && !sync && !ctrl_q.clock_source_sel_hi
                                  && !ctrl_q.clock_source_sel_lo |=> !sck_oe_o)
    else $error("clock pin driven in port mode");
  a_pin_drive: assert property (ce_i && normal && (sync ? !ctrl_q.clock_source_sel_hi
                                : {ctrl_q.clock_source_sel_hi, ctrl_q.clock_source_sel_lo}
                                  == suc_pkg::CKE_OUT) |=> sck_oe_o)
    else $error("clock pin not driven");
  a_ext_input: assert property (ce_i && ctrl_q.clock_source_sel_hi |=> !sck_oe_o)
    else $error("external clock pin driven");
  a_ack_single: assert property (wb_o.ack |=> !wb_o.ack)
    else $error("ack held longer than one cycle");

  c_rx_store: cover property (rx_store);
  c_rx_skip: cover property (rx_fin && rx_skip);
  c_tx_end: cover property (evt_set[suc_pkg::EVT_TXEND]);
  c_irq: cover property ($rose(irq_o));
endmodule // suc_serial_unit

// ### verif/suc_remote.sv
`timescale 1ns/1ps
module suc_remote (
  // Clock
  input wire logic mclk_i,
  // Serial lines
  input wire logic txd_i,
  output logic rxd_o,
  output logic sck_o
);
  // Divider 0: one tick a cycle, sixteen ticks a bit
  localparam int BIT_CYC = 16;
  // Clock pin idles high; only send_clk toggles it from this side
  initial begin
    rxd_o = 1'b1;
    sck_o = 1'b1;
  end
  // Start, data LSB first, mp bit when the format has one, stop
  task automatic send(input logic [7:0] b, input logic fmt, input logic mp);
    logic [10:0] f;
    f = fmt ? {1'b1, mp, b, 1'b0} : {2'b11, b, 1'b0};
    for (int i = 0; i < (fmt ? 11 : 10); i++) begin
      @(posedge mclk_i) rxd_o <= f[i];
      repeat (BIT_CYC - 1) @(posedge mclk_i);
    end
  endtask
  // This side clocks the pin: sixteen pulses a bit async, one a bit sync
  task automatic send_clk(input logic [7:0] b, input logic sync);
    logic [9:0] f;
    f = sync ? {2'b11, b} : {1'b1, b, 1'b0};
    for (int i = 0; i < (sync ? 8 : 10); i++) begin
      @(posedge mclk_i) rxd_o <= f[i];
      repeat (sync ? 1 : 16) begin
        @(posedge mclk_i) sck_o <= 1'b0;
        repeat (2) @(posedge mclk_i);
        sck_o <= 1'b1;
        @(posedge mclk_i);
      end
    end
    // Room for the pin synchronisers before anyone reads the result
    repeat (8) @(posedge mclk_i);
  endtask
  // Gives up after a bounded wait, so a silent line is reported, not hung on
  task automatic recv(output logic [7:0] b, output bit ok);
    int t;
    t = 0;
    ok = 1'b0;
    while (txd_i !== 1'b0 && t < 2000) begin
      @(posedge mclk_i);
      t++;
    end
    if (t < 2000) begin
      ok = 1'b1;
      repeat (BIT_CYC + BIT_CYC / 2) @(posedge mclk_i);
      for (int i = 0; i < 8; i++) begin
        b[i] = txd_i;
        repeat (BIT_CYC) @(posedge mclk_i);
      end
    end
  endtask
endmodule // suc_remote

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic mclk_i, nrst_i, txd, rxd, sck_o, sck_oe, sck_rem;
  logic irq_te, irq_rf, irq_re, irq_tend, irq;
  suc_pkg::suc_wb_req_t wb_q;
  suc_pkg::suc_wb_rsp_t wb_rsp;
  int miscompares = 0;
  int checked = 0;
  logic [31:0] r;
  logic [7:0] b;
  bit ok;
  // Pin level: design drives when enabled, else the remote side
  wire logic sck_pin = sck_oe ? sck_o : sck_rem;
  suc_serial_unit dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(1'b1), .wb_i(wb_q),
    .wb_o(wb_rsp), .rxd_i(rxd), .txd_o(txd), .sck_i(sck_pin), .sck_o(sck_o),
    .sck_oe_o(sck_oe), .tx_empty_irq_o(irq_te), .rx_full_irq_o(irq_rf),
    .rx_error_irq_o(irq_re), .tx_end_irq_o(irq_tend), .irq_o(irq));
  suc_remote rem_u (.mclk_i(mclk_i), .txd_i(txd), .rxd_o(rxd), .sck_o(sck_rem));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge mclk_i);
    wb_q <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge mclk_i);
      t++;
    end while (wb_rsp.ack !== 1'b1 && t < 50);
    r = wb_rsp.dat;
    if (t >= 50) chk("ack", 1, 0);
    wb_q <= '0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, '0);
    chk(nm, e, r);
  endtask
  task automatic t_reset;
    rdc("ctrl", suc_pkg::OFS_CTRL, 32'h0);
    rdc("unmapped", 8'h20, 32'h0);
    chk("irqs", 5'h0, {irq_te, irq_rf, irq_re, irq_tend, irq});
  endtask
  task automatic t_tx;
    wb(1'b1, suc_pkg::OFS_CTRL, 32'h20);
    wb(1'b1, suc_pkg::OFS_TXD, 32'h5A);
    rem_u.recv(b, ok);
    chk("tx byte", 8'h5A, b);
    chk("txe gated", 0, irq_te);
    repeat (40) @(posedge mclk_i);
    wb(1'b1, suc_pkg::OFS_CTRL, 32'hA4);
    wb(1'b1, suc_pkg::OFS_MASK, 32'h9);
    chk("txe irq", 1, irq_te);
    chk("tx end irq", 1, irq_tend);
    chk("irq line", 1, irq);
    rdc("events", suc_pkg::OFS_EVT, 32'h9);
    chk("irq cleared", 0, irq);
    // Data written while the transmitter is off must never reach the line
    wb(1'b1, suc_pkg::OFS_CTRL, 32'h00);
    wb(1'b1, suc_pkg::OFS_TXD, 32'h11);
    rem_u.recv(b, ok);
    chk("tx off", 0, ok);
    wb(1'b1, suc_pkg::OFS_MODE, 32'h4);
    wb(1'b1, suc_pkg::OFS_CTRL, 32'h20);
    wb(1'b1, suc_pkg::OFS_TXD, 32'h22);
    rem_u.recv(b, ok);
    chk("card mode tx", 0, ok);
    wb(1'b1, suc_pkg::OFS_MODE, 32'h0);
  endtask
  task automatic t_rx;
    wb(1'b1, suc_pkg::OFS_CTRL, 32'h40);
    rem_u.send(8'h3C, 1'b0, 1'b0);
    wb(1'b0, suc_pkg::OFS_FLAGS, '0);
    chk("rx off full", 0, r[1]);
    wb(1'b1, suc_pkg::OFS_CTRL, 32'h50);
    rem_u.send(8'hC3, 1'b0, 1'b0);
    chk("rxf irq", 1, irq_rf);
    chk("rx err irq", 0, irq_re);
    // A second frame before the first is read is an overrun
    rem_u.send(8'h0F, 1'b0, 1'b0);
    chk("rx overrun irq", 1, irq_re);
    rdc("rx data", suc_pkg::OFS_RXD, 32'hC3);
    wb(1'b1, suc_pkg::OFS_FLAGS, 32'hC);
    wb(1'b0, suc_pkg::OFS_EVT, '0);
  endtask
  task automatic t_wait;
    wb(1'b1, suc_pkg::OFS_MODE, 32'h2);
    wb(1'b1, suc_pkg::OFS_CTRL, 32'h18);
    rem_u.send(8'h55, 1'b1, 1'b0);
    wb(1'b0, suc_pkg::OFS_FLAGS, '0);
    chk("skip full", 0, r[3:1]);
    rdc("wait kept", suc_pkg::OFS_CTRL, 32'h18);
    rem_u.send(8'h66, 1'b1, 1'b1);
    rdc("wait released", suc_pkg::OFS_CTRL, 32'h10);
    rdc("addr data", suc_pkg::OFS_RXD, 32'h66);
    wb(1'b1, suc_pkg::OFS_MODE, 32'h0);
    wb(1'b1, suc_pkg::OFS_CTRL, 32'h18);
    rem_u.send(8'h77, 1'b0, 1'b0);
    rdc("no mp format", suc_pkg::OFS_RXD, 32'h77);
  endtask
  task automatic t_clk;
    logic [4:0] md = 5'b11000;
    logic [9:0] cs = 10'b10_00_10_01_00;
    logic [4:0] oe = 5'b01010;
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, suc_pkg::OFS_MODE, {31'h0, md[i]});
      wb(1'b1, suc_pkg::OFS_CTRL, {30'h0, cs[2*i+:2]});
      repeat (4) @(posedge mclk_i);
      chk("sck drive", oe[i], sck_oe);
    end
  endtask
  task automatic t_ext;
    wb(1'b1, suc_pkg::OFS_MODE, 32'h1);
    wb(1'b1, suc_pkg::OFS_CTRL, 32'h12);
    rem_u.send_clk(8'hA5, 1'b1);
    rdc("sync ext rx", suc_pkg::OFS_RXD, 32'hA5);
    wb(1'b1, suc_pkg::OFS_CTRL, 32'h02);
    wb(1'b1, suc_pkg::OFS_MODE, 32'h0);
    wb(1'b1, suc_pkg::OFS_CTRL, 32'h12);
    rem_u.send_clk(8'h96, 1'b0);
    rdc("async ext rx", suc_pkg::OFS_RXD, 32'h96);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  initial begin
    #(8 * 60000);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    nrst_i = 1'b0;
    wb_q = '0;
    repeat (20) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_wait();
    t_clk();
    t_ext();
    tally_and_finish();
  end
endmodule // testbench
